// >>> verilog/gpc_pkg.sv
// Package for the general-purpose port controller: register map, reset values, field positions.
// Assumes a 32-bit AXI4-Lite slave, one register per aligned word.
package gpc_pkg;
  // Register byte offsets
  localparam logic [7:0] GPC_OFF_C_VAL   = 8'h00;
  localparam logic [7:0] GPC_OFF_C_DIR   = 8'h04;
  localparam logic [7:0] GPC_OFF_C_PIN   = 8'h08;
  localparam logic [7:0] GPC_OFF_G_VAL   = 8'h0c;
  localparam logic [7:0] GPC_OFF_G_DIR   = 8'h10;
  localparam logic [7:0] GPC_OFF_G_PIN   = 8'h14;
  localparam logic [7:0] GPC_OFF_L_VAL   = 8'h18;
  localparam logic [7:0] GPC_OFF_L_DIR   = 8'h1c;
  localparam logic [7:0] GPC_OFF_L_PIN   = 8'h20;
  localparam logic [7:0] GPC_OFF_I_PIN   = 8'h24;
  localparam logic [7:0] GPC_OFF_STATUS  = 8'h28;
  // Reset values
  localparam logic [7:0] GPC_RST_BYTE    = 8'h00;
  // Port G special bit positions
  localparam int GPC_G_HALT_BIT  = 7;
  localparam int GPC_G_IDLE_BIT  = 6;
  localparam int GPC_G_SKPH_BIT  = 6;
  localparam int GPC_G_DLY_BIT   = 7;
  localparam int GPC_G_FAULT_BIT = 1;
  // Mask of port G bits that behave as ordinary I/O
  localparam logic [7:0] GPC_G_IO_MASK   = 8'h3d;
  // Status register bit positions
  localparam int GPC_ST_HALT_BIT = 0;
  localparam int GPC_ST_IDLE_BIT = 1;
  // AXI responses
  localparam logic [1:0] GPC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] GPC_RESP_SLVERR = 2'b10;
endpackage

// >>> verilog/gpc_pin_cell.sv
// One 8-bit port pin stage: turns direction and value bits into pin drive.
// Assumes pin inputs are synchronous to aclk.
`timescale 1ns/100ps
module gpc_pin_cell
(
  // Clock
  input  wire logic       aclk,
  // Control
  input  wire logic [7:0] dir,
  input  wire logic [7:0] val,
  // Pin side
  input  wire logic [7:0] pin_i,
  output logic      [7:0] pin_o,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pull_en,
  output logic      [7:0] pin_q
);
  // Push-pull when direction set, pull-up only as input with value one
  assign pin_o   = val;
  assign pin_oe  = dir;
  assign pull_en = ~dir & val;

  // Pin levels registered for read-back, separate from the value register
  always_ff @(posedge aclk)
  begin
    pin_q <= pin_i;
  end
endmodule

// >>> verilog/gpc_top.sv
// Port controller top: ports C, G, L and I, port G mode controls, AXI4-Lite registers.
// Assumes one clock aclk at 10 MHz and synchronous pin inputs.
`timescale 1ns/100ps
module gpc_top
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Port C pins
  input  wire logic [7:0]  port_c_i,
  output logic      [7:0]  port_c_o,
  output logic      [7:0]  port_c_oe,
  output logic      [7:0]  port_c_pull,
  // Port G pins
  input  wire logic [7:0]  port_g_i,
  output logic      [7:0]  port_g_o,
  output logic      [7:0]  port_g_oe,
  output logic      [7:0]  port_g_pull,
  // Port L pins
  input  wire logic [7:0]  port_l_i,
  output logic      [7:0]  port_l_o,
  output logic      [7:0]  port_l_oe,
  output logic      [7:0]  port_l_pull,
  // Port I pins, input only
  input  wire logic [7:0]  port_i_i,
  // Option strap and system side
  input  wire logic        rc_osc_option,
  input  wire logic        osc_clock,
  input  wire logic        supervisor_fault,
  input  wire logic        halt_exit,
  input  wire logic        idle_exit,
  output logic             halt_req,
  output logic             idle_req,
  output logic             halt_wake,
  output logic             serial_clock_alt_phase,
  output logic             halt_exit_delay_enable,
  // Alternate functions seen by peripherals
  output logic [7:0]       multi_pin_wakeup,
  output logic             serial_port_ext_clock,
  output logic             serial_port_receive,
  input  wire logic        serial_port_transmit,
  output logic             timer2_input_a,
  output logic             timer2_input_b,
  output logic             timer3_input_a,
  output logic             timer3_input_b,
  output logic             serial_data_in,
  output logic             serial_shift_clock,
  output logic             serial_data_out_pin,
  output logic             timer1_io_pin,
  output logic             timer1_capture_pin,
  output logic             external_interrupt_pin,
  output logic [2:0]       comparator1_pins,
  output logic [2:0]       comparator2_pins
);
  // Control registers
  logic [7:0] c_val_q, c_dir_q, g_val_q, g_dir_q, l_val_q, l_dir_q;
  logic       halt_q, idle_q, g7_prev_q;
  logic [7:0] c_pin, g_pin, l_pin, i_pin_q;
  logic [7:0] g_o_raw, g_oe_raw, g_pull_raw;
  // Bus state
  logic       aw_held_q, w_held_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;

  // Word-aligned offset decode shared by reads and writes
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= GPC_OFF_STATUS);
  endfunction

  // Write path: address and data accepted independently, in either order
  wire do_write = aw_held_q && w_held_q && !bvalid_q;
  wire wr_en    = do_write && wstrb_q[0];
  wire wr_c_val = wr_en && awaddr_q == GPC_OFF_C_VAL;
  wire wr_c_dir = wr_en && awaddr_q == GPC_OFF_C_DIR;
  wire wr_g_val = wr_en && awaddr_q == GPC_OFF_G_VAL;
  wire wr_g_dir = wr_en && awaddr_q == GPC_OFF_G_DIR;
  wire wr_l_val = wr_en && awaddr_q == GPC_OFF_L_VAL;
  wire wr_l_dir = wr_en && awaddr_q == GPC_OFF_L_DIR;
  wire [7:0] wbyte = wdata_q[7:0];
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Bus handshake registers; one write in flight at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= GPC_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(awaddr_q) ? GPC_RESP_OKAY : GPC_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Direction and value registers cleared so pins start high impedance, all but G1 and, without the RC option, G7
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c_val_q <= GPC_RST_BYTE;
      c_dir_q <= GPC_RST_BYTE;
      g_val_q <= GPC_RST_BYTE;
      g_dir_q <= GPC_RST_BYTE;
      l_val_q <= GPC_RST_BYTE;
      l_dir_q <= GPC_RST_BYTE;
    end
    else
    begin
      if (wr_c_val) c_val_q <= wbyte;
      if (wr_c_dir) c_dir_q <= wbyte;
      if (wr_g_val) g_val_q <= wbyte;
      if (wr_g_dir) g_dir_q <= wbyte;
      if (wr_l_val) l_val_q <= wbyte;
      if (wr_l_dir) l_dir_q <= wbyte;
    end
  end

  // G7 rising edge is the halt wake only with the RC option
  wire g7_rise = rc_osc_option && port_g_i[GPC_G_HALT_BIT] && !g7_prev_q;
  assign halt_wake = g7_rise;

  // Halt held until halt_exit or a G7 wake, idle until idle_exit; a write setting wins over exit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      halt_q    <= 1'b0;
      idle_q    <= 1'b0;
      g7_prev_q <= 1'b1;               // Seen high: a pin held high gives no false wake
      i_pin_q   <= 8'h00;
    end
    else
    begin
      g7_prev_q <= port_g_i[GPC_G_HALT_BIT];
      i_pin_q   <= port_i_i;
      if (wr_g_val && wbyte[GPC_G_HALT_BIT])
        halt_q <= 1'b1;
      else if (halt_exit || g7_rise)
        halt_q <= 1'b0;
      if (wr_g_val && wbyte[GPC_G_IDLE_BIT])
        idle_q <= 1'b1;
      else if (idle_exit)
        idle_q <= 1'b0;
    end
  end
  assign halt_req = halt_q;
  assign idle_req = idle_q;
  assign serial_clock_alt_phase = g_dir_q[GPC_G_SKPH_BIT];
  assign halt_exit_delay_enable = rc_osc_option && g_dir_q[GPC_G_DLY_BIT];

  // Pin stages for the three bidirectional ports
  gpc_pin_cell u_port_c
  (
    .aclk    (aclk),
    .dir     (c_dir_q),
    .val     (c_val_q),
    .pin_i   (port_c_i),
    .pin_o   (port_c_o),
    .pin_oe  (port_c_oe),
    .pull_en (port_c_pull),
    .pin_q   (c_pin)
  );
  gpc_pin_cell u_port_g
  (
    .aclk    (aclk),
    .dir     (g_dir_q),
    .val     (g_val_q),
    .pin_i   (port_g_i),
    .pin_o   (g_o_raw),
    .pin_oe  (g_oe_raw),
    .pull_en (g_pull_raw),
    .pin_q   (g_pin)
  );
  gpc_pin_cell u_port_l
  (
    .aclk    (aclk),
    .dir     (l_dir_q),
    .val     (l_val_q),
    .pin_i   (port_l_i),
    .pin_o   (port_l_o),
    .pin_oe  (port_l_oe),
    .pull_en (port_l_pull),
    .pin_q   (l_pin)
  );

  // Port G: only bits 0,2-5 are configurable; G1 fault, G6 input, G7 clock or input
  wire g7_drive = !rc_osc_option;
  assign port_g_o    = {osc_clock, 1'b0, g_o_raw[5:2], supervisor_fault, g_o_raw[0]};
  assign port_g_oe   = {g7_drive, 1'b0, g_oe_raw[5:2], 1'b1, g_oe_raw[0]};
  assign port_g_pull = g_pull_raw & GPC_G_IO_MASK;

  // Alternate functions of ports G, L and I
  assign multi_pin_wakeup       = l_pin;
  assign serial_port_ext_clock  = l_pin[1];
  assign serial_port_receive    = l_pin[3];
  assign timer2_input_a         = l_pin[4];
  assign timer2_input_b         = l_pin[5];
  assign timer3_input_a         = l_pin[6];
  assign timer3_input_b         = l_pin[7];
  assign serial_data_in         = g_pin[6];
  assign serial_shift_clock     = g_pin[5];
  assign serial_data_out_pin    = g_o_raw[4];
  assign timer1_io_pin          = g_pin[3];
  assign timer1_capture_pin     = g_pin[2];
  assign external_interrupt_pin = g_pin[0];
  assign comparator1_pins       = i_pin_q[3:1];
  assign comparator2_pins       = i_pin_q[6:4];

  // Read data mux; floating pins of small packages pass through unmasked
  wire [7:0] g_val_rd = g_val_q & 8'h3f;
  wire [7:0] rd_byte =
      (s_axi_araddr == GPC_OFF_C_VAL)  ? c_val_q  :
      (s_axi_araddr == GPC_OFF_C_DIR)  ? c_dir_q  :
      (s_axi_araddr == GPC_OFF_C_PIN)  ? c_pin    :
      (s_axi_araddr == GPC_OFF_G_VAL)  ? g_val_rd :
      (s_axi_araddr == GPC_OFF_G_DIR)  ? g_dir_q  :
      (s_axi_araddr == GPC_OFF_G_PIN)  ? g_pin    :
      (s_axi_araddr == GPC_OFF_L_VAL)  ? l_val_q  :
      (s_axi_araddr == GPC_OFF_L_DIR)  ? l_dir_q  :
      (s_axi_araddr == GPC_OFF_L_PIN)  ? l_pin    :
      (s_axi_araddr == GPC_OFF_I_PIN)  ? i_pin_q  :
      (s_axi_araddr == GPC_OFF_STATUS) ? {6'h00, idle_q, halt_q} : 8'h00;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Read channel: answer one cycle after address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= GPC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_byte};
      rresp_q  <= mapped(s_axi_araddr) ? GPC_RESP_OKAY : GPC_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Assertions
  AST_RESET_HIZ: assert property (@(posedge aclk) !aresetn |=> port_c_oe == 8'h00 && port_l_oe == 8'h00)
    else $error("pins not high impedance after reset");
  AST_MODE_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
    port_l_pull == (~l_dir_q & l_val_q) && port_l_oe == l_dir_q)
    else $error("pin mode mismatch");
  AST_DIR_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_c_dir |=> c_dir_q == $past(wbyte))
    else $error("direction write lost");
  AST_PIN_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 g_pin == $past(port_g_i))
    else $error("pin read not current");
  AST_HALT: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_g_val && wbyte[7] |=> halt_req)
    else $error("halt not entered");
  AST_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_g_val && wbyte[6] |=> idle_req)
    else $error("idle not entered");
  AST_SK_PHASE: assert property (@(posedge aclk) disable iff (!aresetn)
    serial_clock_alt_phase == g_dir_q[6])
    else $error("phase bit mismatch");
  AST_DLY: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_exit_delay_enable |-> rc_osc_option && g_dir_q[7])
    else $error("delay enable wrong");
  AST_G_RDZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_q && $past(s_axi_araddr) == GPC_OFF_G_VAL && $rose(rvalid_q) |-> rdata_q[7:6] == 2'b00)
    else $error("mode bits read nonzero");
  AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    halt_q && g7_rise && !(wr_g_val && wbyte[7]) |=> !halt_q)
    else $error("G7 rise did not wake");
  AST_G1_OUT: assert property (@(posedge aclk) disable iff (!aresetn)
    port_g_oe[1] && port_g_o[1] == supervisor_fault && !port_g_oe[6])
    else $error("fixed G pins wrong");
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the port controller: register access, pin modes, port G controls, alternate pins.
// Assumes gpc_pkg offsets, a 10 MHz aclk and a bench that drives every input itself.
`timescale 1ns/100ps
module tb;
  import gpc_pkg::*;
  typedef struct {logic [7:0] a; logic wr; logic [31:0] d; logic [31:0] e;} gpc_row_s;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rc_osc_option, osc_clock, supervisor_fault;
  logic        halt_exit, idle_exit, halt_req, idle_req, halt_wake, serial_clock_alt_phase, halt_exit_delay_enable;
  logic        serial_port_ext_clock, serial_port_receive, serial_port_transmit, timer2_input_a, timer2_input_b;
  logic        timer3_input_a, timer3_input_b, serial_data_in, serial_shift_clock, serial_data_out_pin;
  logic        timer1_io_pin, timer1_capture_pin, external_interrupt_pin, w;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, port_c_i, port_c_o, port_c_oe, port_c_pull, port_g_i, port_g_o;
  logic [7:0]  port_g_oe, port_g_pull, port_l_i, port_l_o, port_l_oe, port_l_pull, port_i_i, multi_pin_wakeup;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  comparator1_pins, comparator2_pins;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  int          n_fail, cmp_count;
  gpc_row_s    rows [10];

  gpc_top dut
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_c_i, .port_c_o, .port_c_oe, .port_c_pull,
    .port_g_i, .port_g_o, .port_g_oe, .port_g_pull, .port_l_i, .port_l_o, .port_l_oe, .port_l_pull, .port_i_i,
    .rc_osc_option, .osc_clock, .supervisor_fault, .halt_exit, .idle_exit, .halt_req, .idle_req, .halt_wake,
    .serial_clock_alt_phase, .halt_exit_delay_enable, .multi_pin_wakeup, .serial_port_ext_clock,
    .serial_port_receive, .serial_port_transmit, .timer2_input_a, .timer2_input_b, .timer3_input_a,
    .timer3_input_b, .serial_data_in, .serial_shift_clock, .serial_data_out_pin, .timer1_io_pin,
    .timer1_capture_pin, .external_interrupt_pin, .comparator1_pins, .comparator2_pins
  );

  // 100 ns clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Verdict in one place, also reached by a stuck bus wait
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk_val({24'h0, got}, {24'h0, exp});
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus waits are bounded; a lost response would otherwise hang the run
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      n_fail++;
      $display("BAD %0t bus response never came", $time);
      stop_test();
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      n++;
    end
    while (s_axi_bvalid !== 1'b1 && n < 40);
    tmo(n);
    r = s_axi_bresp;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      n++;
    end
    while (s_axi_rvalid !== 1'b1 && n < 40);
    tmo(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, rs);
    chk_val({30'h0, rs}, {30'h0, GPC_RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axr(a, rd, rs);
    chk_val({30'h0, rs}, {30'h0, GPC_RESP_OKAY});
    chk_val(rd, e);
  endtask

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    {rc_osc_option, osc_clock, halt_exit, idle_exit, serial_port_transmit} = '0;
    supervisor_fault = 1'b1;
    port_c_i = 8'h96;
    port_g_i = 8'h4e;
    port_l_i = 8'h3b;
    port_i_i = 8'hc7;
    n_fail = 0;
    cmp_count = 0;
    rows = '{'{GPC_OFF_C_VAL, 1, 32'ha5, 32'ha5}, '{GPC_OFF_C_DIR, 1, 32'h3c, 32'h3c},
             '{GPC_OFF_L_VAL, 1, 32'h5a, 32'h5a}, '{GPC_OFF_L_DIR, 1, 32'hf0, 32'hf0},
             '{GPC_OFF_G_VAL, 1, 32'hff3d, 32'h3d}, '{GPC_OFF_G_DIR, 1, 32'h3c, 32'h3c},
             '{GPC_OFF_C_PIN, 0, 0, 32'h96}, '{GPC_OFF_G_PIN, 0, 0, 32'h4e},
             '{GPC_OFF_L_PIN, 0, 0, 32'h3b}, '{GPC_OFF_I_PIN, 0, 0, 32'hc7}};
    cyc(8);
    aresetn <= 1'b1;
    cyc(1);
    // Every pin starts undriven, crystal option keeps G1 and G7 driven
    chk8(port_c_oe, 8'h00);
    chk8(port_l_oe | port_l_pull | port_c_pull, 8'h00);
    chk8(port_g_oe, 8'h82);
    for (int k = 0; k < 8; k++)
      if (k % 3 != 2)
        rd_chk(8'(k * 4), 32'h0);
    $display("reset test finished");
    // Table: register write-back and pin reads
    foreach (rows[k])
    begin
      if (rows[k].wr)
        wr(rows[k].a, rows[k].d);
      rd_chk(rows[k].a, rows[k].e);
    end
    chk8(port_c_o, 8'ha5);
    chk8(port_c_oe, 8'h3c);
    chk8(port_c_pull, 8'h81);
    chk8(port_l_o, 8'h5a);
    chk8(port_l_oe, 8'hf0);
    chk8(port_l_pull, 8'h0a);
    chk8(port_g_o & 8'hbf, 8'h3f);
    chk8(port_g_oe, 8'hbe);
    chk8(port_g_pull, 8'h01);
    chk_bit(serial_data_out_pin, 1'b1);
    // Alternate pin functions follow the pins
    chk_val(32'({multi_pin_wakeup, serial_port_ext_clock, serial_port_receive, timer2_input_a, timer2_input_b,
             timer3_input_a, timer3_input_b}),
            32'({port_l_i, port_l_i[1], port_l_i[3], port_l_i[4], port_l_i[5], port_l_i[6], port_l_i[7]}));
    chk_val(32'({serial_data_in, serial_shift_clock, timer1_io_pin, timer1_capture_pin, external_interrupt_pin}),
            32'({port_g_i[6:5], port_g_i[3:2], port_g_i[0]}));
    chk_val(32'({comparator1_pins, comparator2_pins}), 32'({port_i_i[3:1], port_i_i[6:4]}));
    // Software masks port I bits that may float in small packages
    axr(GPC_OFF_I_PIN, rd, rs);
    chk8(rd[7:0] & 8'h7e, port_i_i & 8'h7e);
    $display("table test finished");
    // Halt and idle entry; mode bits never read back
    wr(GPC_OFF_G_VAL, 32'h80);
    cyc(1);
    chk_bit(halt_req, 1'b1);
    rd_chk(GPC_OFF_G_VAL, 32'h0);
    rd_chk(GPC_OFF_STATUS, 32'h1);
    halt_exit <= 1'b1;
    cyc(1);
    halt_exit <= 1'b0;
    wr(GPC_OFF_G_VAL, 32'h40);
    cyc(1);
    chk_bit(idle_req, 1'b1);
    chk_bit(halt_req, 1'b0);
    rd_chk(GPC_OFF_G_VAL, 32'h0);
    idle_exit <= 1'b1;
    cyc(1);
    idle_exit <= 1'b0;
    cyc(2);
    chk_bit(idle_req, 1'b0);
    $display("halt idle test finished");
    // Clock phase and delay enable; the delay only counts with the RC option
    wr(GPC_OFF_G_DIR, 32'hc0);
    chk_bit(serial_clock_alt_phase, 1'b1);
    chk_bit(halt_exit_delay_enable, 1'b0);
    rc_osc_option <= 1'b1;
    port_g_i <= 8'h00;
    cyc(2);
    chk_bit(halt_exit_delay_enable, 1'b1);
    chk8(port_g_oe & 8'h80, 8'h00);
    // A G7 rise wakes the chip from halt
    wr(GPC_OFF_G_VAL, 32'h80);
    cyc(1);
    chk_bit(halt_req, 1'b1);
    port_g_i <= 8'h80;
    w = 1'b0;
    // Wake pulse stands one cycle; look at it mid-cycle where it is settled
    repeat (4)
    begin
      @(negedge aclk);
      w = w | (halt_wake === 1'b1);
    end
    @(posedge aclk);
    chk_bit(w, 1'b1);
    chk_bit(halt_req, 1'b0);
    $display("wake test finished");
    // Partial strobe, misaligned and unmapped places
    s_axi_wstrb <= 4'he;
    wr(GPC_OFF_C_VAL, 32'h11);
    s_axi_wstrb <= 4'hf;
    rd_chk(GPC_OFF_C_VAL, 32'ha5);
    axw(8'h01, 32'h0, rs);
    chk_val({30'h0, rs}, {30'h0, GPC_RESP_SLVERR});
    axr(8'h2c, rd, rs);
    chk_val({rd[29:0], rs}, {30'h0, GPC_RESP_SLVERR});
    $display("bus error test finished");
    // Interrupt input held high, then low, for more than one cycle each
    port_g_i <= 8'h81;
    cyc(2);
    chk_bit(external_interrupt_pin, 1'b1);
    port_g_i <= 8'h80;
    cyc(2);
    chk_bit(external_interrupt_pin, 1'b0);
    $display("interrupt hold test finished");
    // Reset again in mid-run
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    chk8(port_c_oe, 8'h00);
    chk_bit(serial_clock_alt_phase, 1'b0);
    chk_bit(halt_wake, 1'b0);
    rd_chk(GPC_OFF_C_DIR, 32'h0);
    $display("second reset test finished");
    stop_test();
  end
endmodule
